// ==== testbench/mct_pin_model.sv ====
module mct_pin_model
  import mct_pkg::*;
(
  // levels the bench wants on undriven pins
  input wire logic [NPIN-1:0] pinDrv,
  // timer pin side
  input wire logic [NPIN-1:0] ioOut,
  input wire logic [NPIN-1:0] ioOe,
  output logic [NPIN-1:0] ioIn,
  output logic extClkIn,
  output logic [1:0] phaseA,
  output logic [1:0] phaseB
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pin the timer drives reads back its own level, so a capture
  // source never fights a compare output
  assign ioIn = (ioOe & ioOut) | (~ioOe & pinDrv);
  // no encoder or external clock fitted: lines rest low
  assign extClkIn = 1'b0;
  assign phaseA = 2'h0;
  assign phaseB = 2'h0;
endmodule // mct_pin_model

// ==== testbench/testbench.sv ====
module testbench
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, extClkIn;
  logic [1:0] htrans, phaseA, phaseB;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, p, c2, g2;
  logic [NPIN-1:0] ioIn, ioOut, ioOe, pinDrv;
  logic [NCH-1:0] irqReq;
  int n_mismatch, n_checks;

  mct_timer u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .extClkIn(extClkIn), .phaseA(phaseA), .phaseB(phaseB),
    .irqReq(irqReq));
  mct_pin_model u_pins (.pinDrv(pinDrv), .ioOut(ioOut), .ioOe(ioOe),
    .ioIn(ioIn), .extClkIn(extClkIn), .phaseA(phaseA), .phaseB(phaseB));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ra(int ch, logic [3:0] off);
    return 32'h40 * (ch + 1) + {26'h0, off, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // entered just after a rising edge; read data lands in rd
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 32'd22125;
    n_mismatch = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, pinDrv} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    bus(ra(0, O_CTRL), 1'b0, 0); chk(rd, 32'h0);
    bus(ra(0, O_GRA), 1'b0, 0); chk(rd, 32'hffff);
    bus(32'h400, 1'b0, 0); chk(rd, 32'h0);
    chk(hresp, 1'b0);
    $display("reset test ends");
    // counter is stopped while set up, then started
    bus(ra(0, O_CNT), 1'b1, 32'hfffe);
    bus(ra(0, O_GRA), 1'b1, 32'h2);
    bus(ra(0, O_IO), 1'b1, 32'h13);
    bus(ra(0, O_IER), 1'b1, 32'h10);
    bus(A_RUN, 1'b1, 32'h1);
    repeat (20) @(posedge core_clk);
    bus(A_RUN, 1'b1, 32'h0);
    bus(ra(0, O_FLG), 1'b0, 0); chk(rd & 32'h13, 32'h13);
    bus(ra(0, O_CNT), 1'b0, 0); chk(rd > 3 && rd < 32'h20, 1);
    chk(irqReq[0], 1'b1);
    chk(ioOut[1:0], 2'h1);
    repeat (5) @(posedge core_clk);
    chk(ioOut[1:0], 2'h1);
    bus(ra(0, O_FLG), 1'b1, 32'h3f);
    bus(ra(0, O_FLG), 1'b0, 0); chk(rd, 32'h0);
    $display("overflow test ends");
    p = 32'h3 + (rnd() & 32'h7);
    bus(ra(1, O_GRA), 1'b1, p);
    bus(ra(1, O_CTRL), 1'b1, 32'h8);
    bus(ra(1, O_IO), 1'b1, 32'h2);
    bus(ra(1, O_IER), 1'b1, 32'h1);
    bus(A_RUN, 1'b1, 32'h2);
    repeat (40) @(posedge core_clk);
    bus(A_RUN, 1'b1, 32'h0);
    bus(ra(1, O_CNT), 1'b0, 0); chk(rd <= p, 1);
    bus(ra(1, O_FLG), 1'b0, 0); chk(rd[0], 1'b1);
    chk(irqReq[1], 1'b1);
    chk(ioOut[4], 1'b1);
    chk(ioOe[4], 1'b1);
    $display("periodic test ends");
    bus(A_RUN, 1'b1, 32'h4);
    for (int e = 1; e < 4; e++) begin
      bus(ra(2, O_IO), 1'b1, 32'h8 | e);
      for (int lv = 1; lv >= 0; lv--) begin
        bus(ra(2, O_FLG), 1'b1, 32'h1);
        pinDrv[8] <= lv[0];
        repeat (10) @(posedge core_clk);
        bus(ra(2, O_FLG), 1'b0, 0); chk(rd[0], lv[0] ? e[0] : e[1]);
      end
    end
    bus(A_RUN, 1'b1, 32'h0);
    bus(ra(2, O_CNT), 1'b0, 0);
    c2 = rd;
    bus(ra(2, O_GRA), 1'b0, 0);
    g2 = rd;
    chk(c2 - g2 > 3 && c2 - g2 < 32'h40, 1);
    $display("capture test ends");
    // synchronous mode needs two channels marked
    bus(A_SYNC, 1'b1, 32'h3);
    p = rnd() & 32'hffff;
    bus(ra(0, O_CNT), 1'b1, p);
    bus(ra(1, O_CNT), 1'b0, 0); chk(rd, p);
    bus(ra(2, O_CNT), 1'b0, 0); chk(rd, c2);
    $display("sync test ends");
    // lower half of pair 1/2 wraps once; channel 0 buffers a with c
    bus(ra(1, O_CTRL), 1'b1, 32'h5);
    bus(ra(0, O_CTRL), 1'b1, 32'h40);
    bus(ra(0, O_GRA + 4'h2), 1'b1, 32'h30);
    bus(ra(2, O_CNT), 1'b1, 32'hfff8);
    bus(ra(1, O_CNT), 1'b1, 32'h0);
    bus(ra(0, O_CNT), 1'b0, 0); chk(rd, 32'h0);
    bus(A_RUN, 1'b1, 32'h7);
    repeat (20) @(posedge core_clk);
    bus(A_RUN, 1'b1, 32'h0);
    bus(ra(1, O_CNT), 1'b0, 0); chk(rd, 32'h1);
    bus(ra(0, O_GRA), 1'b0, 0); chk(rd, 32'h30);
    chk(ioOut[0], 1'b0);
    $display("cascade and buffer test ends");
    tally_and_finish();
  end
endmodule // testbench

// ==== verilog/mct_pin_sync.sv ====
module mct_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a level counts only once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule // mct_pin_sync

// ==== verilog/mct_pkg.sv ====
// What this block does
// - setting a channel run bit starts its counter on the selected count clock
// - after reset every counter is free-running with no clearing source
// - wrap from all ones to zero sets the channel overflow flag
// - overflow flag with its enable set raises the channel interrupt request
// - after overflow the counter keeps counting up from zero
// - compare match selected as clear source sets match flag and zeroes counter
// - match or capture flag with its enable set raises the interrupt request
// - compare match drives the channel pin low, high or toggles it
// - a match whose set level equals the pin level leaves the pin unchanged
// - a selected rising, falling or both edge copies the counter into the register
// - channels 0, 1, 3, 4 may capture on another channel clock or match
// - capture on a neighbour count clock never fires when that clock is undivided
// - counter write on a synchronous channel loads all synchronous counters together
// - synchronous-clear channels clear when another synchronous channel clears itself
// - buffer mode only on channels 0 and 3, pairing A with C, B with D
// - buffered compare match changes output and loads buffer into compare register
// - buffered capture moves counter to register and old register to buffer
// - cascaded upper channel counts each overflow or underflow of the lower channel
// - lower cascade channel underflows only while in phase counting mode
// - upper channel in phase counting ignores its clock select and counts phases
// - clearing a run bit stops the counter and holds the pin output level
package mct_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NCH = 6;
  localparam int NGR = 4;
  localparam int GR_PAIR = 2;
  localparam int CW = 16;
  localparam int PRE_W = 6;
  localparam int NPIN = NCH * NGR;
  localparam int P_EXT = NPIN;
  localparam int P_PHA = NPIN + 1;
  localparam int P_PHB = NPIN + 3;
  localparam int NSYNC = NPIN + 5;
  localparam logic [NCH-1:0] BUF_CH = 6'h09;
  localparam logic [NCH-1:0] PH_CH = 6'h36;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int CH_LSB = 6;
  localparam int CH_W = 3;
  localparam int WD_LSB = 2;
  localparam int WD_W = 4;
  localparam logic [ADDR_W-1:0] A_RUN = 9'h000;
  localparam logic [ADDR_W-1:0] A_SYNC = 9'h004;
  localparam logic [WD_W-1:0] O_CTRL = 4'h0;
  localparam logic [WD_W-1:0] O_IO = 4'h1;
  localparam logic [WD_W-1:0] O_IER = 4'h2;
  localparam logic [WD_W-1:0] O_FLG = 4'h3;
  localparam logic [WD_W-1:0] O_CNT = 4'h4;
  localparam logic [WD_W-1:0] O_GRA = 4'h5;
  localparam logic [WD_W-1:0] O_GRD = 4'h8;
  // ------------------------------------------------------------
  // fields and codes
  // ------------------------------------------------------------
  localparam int CTRL_W = 9;
  localparam int CT_CK = 0;
  localparam int CT_CL = 3;
  localparam int CT_BUFA = 6;
  localparam int CT_PHASE = 8;
  localparam logic [2:0] CK_DIV1 = 3'h0;
  localparam logic [2:0] CK_DIV4 = 3'h1;
  localparam logic [2:0] CK_DIV16 = 3'h2;
  localparam logic [2:0] CK_DIV64 = 3'h3;
  localparam logic [2:0] CK_EXT = 3'h4;
  localparam logic [2:0] CK_CASC = 3'h5;
  localparam logic [2:0] CL_NONE = 3'h0;
  localparam logic [2:0] CL_GRA = 3'h1;
  localparam logic [2:0] CL_GRD = 3'h4;
  localparam logic [2:0] CL_SYNC = 3'h7;
  localparam int IO_W = 4;
  localparam int IO_OTHER = 2;
  localparam int IO_CAP = 3;
  localparam logic [1:0] OM_NONE = 2'h0;
  localparam logic [1:0] OM_LOW = 2'h1;
  localparam logic [1:0] OM_HIGH = 2'h2;
  localparam logic [1:0] OM_TOG = 2'h3;
  localparam logic [1:0] CE_RISE = 2'h1;
  localparam logic [1:0] CE_FALL = 2'h2;
  localparam logic [1:0] CE_BOTH = 2'h3;
  localparam int FLG_W = 6;
  localparam int FL_OVF = 4;
  localparam int FL_UDF = 5;
  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [CW-1:0] CNT_MAX = 16'hffff;
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_ONE = 16'h0001;
  localparam logic [CW-1:0] GR_RST = 16'hffff;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== verilog/mct_timer.sv ====
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
module mct_timer
  import mct_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // channel pins
  input wire logic [NPIN-1:0] ioIn,
  output logic [NPIN-1:0] ioOut,
  output logic [NPIN-1:0] ioOe,
  // external count clock and phase inputs
  input wire logic extClkIn,
  input wire logic [1:0] phaseA,
  input wire logic [1:0] phaseB,
  // interrupt requests
  output logic [NCH-1:0] irqReq
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic divTick(input logic [2:0] s,
                                   input logic [PRE_W-1:0] p);
    if (s == CK_DIV1) return 1'b1;
    else if (s == CK_DIV4) return &p[1:0];
    else if (s == CK_DIV16) return &p[3:0];
    else if (s == CK_DIV64) return &p;
    else return 1'b0;
  endfunction

  // c and d act only on channels 0 and 3, and there only while they do not buffer a or b
  function automatic logic gValid(input int c, input int g,
                                  input logic [CTRL_W-1:0] ct);
    if (g < GR_PAIR) return 1'b1;
    return BUF_CH[c] && !ct[CT_BUFA + g - GR_PAIR];
  endfunction

  function automatic logic chOk(input logic [ADDR_W-1:0] a);
    return a[CH_LSB +: CH_W] != 3'h0 && a[CH_LSB +: CH_W] <= NCH;
  endfunction

  function automatic logic [CH_W-1:0] chNum(input logic [ADDR_W-1:0] a);
    return a[CH_LSB +: CH_W] - 3'h1;
  endfunction

  function automatic int phPin(input int c);
    return (c == 1 || c == 5) ? 0 : 1;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NCH-1:0] run, syncSel, tick, up, ovfEv, udfEv;
  logic [NCH-1:0] clrOwn, clrNow, presetNow, chWr;
  logic [CTRL_W-1:0] ctrl [NCH];
  logic [NGR*IO_W-1:0] io [NCH];
  logic [FLG_W-1:0] ier [NCH];
  logic [FLG_W-1:0] flg [NCH];
  logic [CW-1:0] cnt [NCH];
  logic [CW-1:0] gr [NCH][NGR];
  logic [PRE_W-1:0] pre;
  logic [NSYNC-1:0] pinLvl, pinPrev, rises, falls;
  logic wrQ, allFree;
  logic [ADDR_W-1:0] adrQ;
  logic [31:0] rdVal;
  logic [NGR-1:0] matchEv [NCH];
  logic [NGR-1:0] capEv [NCH];

  // ------------------------------------------------------------
  // pin inputs
  // ------------------------------------------------------------
  mct_pin_sync #(.W(NSYNC)) pinSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .raw({phaseB, phaseA, extClkIn, ioIn}),
    .level(pinLvl)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) pinPrev <= '0;
    else pinPrev <= pinLvl;
  end

  assign rises = pinLvl & ~pinPrev;
  assign falls = ~pinLvl & pinPrev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) pre <= '0;
    else pre <= pre + PRE_ONE;
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // zero wait states: read data is sampled in the address phase
  always_comb begin
    logic [ADDR_W-1:0] ra;
    logic [WD_W-1:0] wd;
    logic [CH_W-1:0] rc;
    ra = haddr[ADDR_W-1:0];
    wd = ra[WD_LSB +: WD_W];
    rc = chNum(ra);
    rdVal = '0;
    if (haddr[31:ADDR_W] != '0) begin
      rdVal = '0;
    end else if (ra == A_RUN) begin
      rdVal[NCH-1:0] = run;
    end else if (ra == A_SYNC) begin
      rdVal[NCH-1:0] = syncSel;
    end else if (chOk(ra) && wd == O_CTRL) begin
      rdVal[CTRL_W-1:0] = ctrl[rc];
    end else if (chOk(ra) && wd == O_IO) begin
      rdVal[NGR*IO_W-1:0] = io[rc];
    end else if (chOk(ra) && wd == O_IER) begin
      rdVal[FLG_W-1:0] = ier[rc];
    end else if (chOk(ra) && wd == O_FLG) begin
      rdVal[FLG_W-1:0] = flg[rc];
    end else if (chOk(ra) && wd == O_CNT) begin
      rdVal[CW-1:0] = cnt[rc];
    end else if (chOk(ra) && wd >= O_GRA && wd <= O_GRD) begin
      rdVal[CW-1:0] = gr[rc][2'(wd - O_GRA)];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= '0;
      wrQ <= 1'b0;
      adrQ <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      wrQ <= hsel && hready && htrans[1] && hwrite
             && haddr[31:ADDR_W] == '0;
      if (hsel && hready && htrans[1]) adrQ <= haddr[ADDR_W-1:0];
      if (hsel && hready && htrans[1] && !hwrite) hrdata <= rdVal;
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chWr[c] = wrQ && chOk(adrQ) && chNum(adrQ) == c;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run <= '0;
      syncSel <= '0;
    end else begin
      if (wrQ && adrQ == A_RUN) run <= hwdata[NCH-1:0];
      if (wrQ && adrQ == A_SYNC) syncSel <= hwdata[NCH-1:0];
    end
  end

  // ------------------------------------------------------------
  // count events, lower cascade partner (higher channel number) evaluated first
  // ------------------------------------------------------------
  always_comb begin
    for (int c = NCH - 1; c >= 0; c--) begin
      tick[c] = 1'b0;
      up[c] = 1'b1;
      if (PH_CH[c] && ctrl[c][CT_PHASE]) begin
        tick[c] = rises[P_PHA + phPin(c)];
        up[c] = !pinLvl[P_PHB + phPin(c)];
      end else if (ctrl[c][CT_CK +: 3] == CK_EXT) begin
        tick[c] = rises[P_EXT];
      end else if (ctrl[c][CT_CK +: 3] == CK_CASC) begin
        if (c == 1) tick[c] = ovfEv[2] | udfEv[2];
        else if (c == 4) tick[c] = ovfEv[5] | udfEv[5];
      end else begin
        tick[c] = divTick(ctrl[c][CT_CK +: 3], pre);
      end
      tick[c] = tick[c] & run[c];
      ovfEv[c] = tick[c] && up[c] && cnt[c] == CNT_MAX;
      // down counting only exists in phase mode
      udfEv[c] = tick[c] && !up[c] && cnt[c] == CNT_ZERO;
      for (int g = 0; g < NGR; g++) begin
        matchEv[c][g] = tick[c] && gValid(c, g, ctrl[c])
                        && !io[c][g*IO_W + IO_CAP] && cnt[c] == gr[c][g];
      end
    end
  end

  always_comb begin
    logic anyClr;
    logic [1:0] em;
    logic src;
    logic [2:0] cs;
    anyClr = 1'b0;
    em = 2'h0;
    src = 1'b0;
    cs = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      for (int g = 0; g < NGR; g++) begin
        em = io[c][g*IO_W +: 2];
        src = ((em == CE_RISE || em == CE_BOTH) && rises[c*NGR + g])
              || ((em == CE_FALL || em == CE_BOTH) && falls[c*NGR + g]);
        if (io[c][g*IO_W + IO_OTHER]) begin
          if (c == 0) src = tick[1] && ctrl[1][CT_CK +: 3] != CK_DIV1;
          else if (c == 3) src = tick[4] && ctrl[4][CT_CK +: 3] != CK_DIV1;
          else if (c == 1) src = matchEv[0][0];
          else if (c == 4) src = matchEv[3][0];
        end
        capEv[c][g] = src && gValid(c, g, ctrl[c])
                      && io[c][g*IO_W + IO_CAP];
      end
      cs = ctrl[c][CT_CL +: 3];
      clrOwn[c] = cs >= CL_GRA && cs <= CL_GRD
                  && (matchEv[c][2'(cs - CL_GRA)] || capEv[c][2'(cs - CL_GRA)]);
    end
    anyClr = |(clrOwn & syncSel);
    allFree = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      clrNow[c] = clrOwn[c] || (syncSel[c] && anyClr
                  && ctrl[c][CT_CL +: 3] == CL_SYNC);
      presetNow[c] = wrQ && chOk(adrQ) && adrQ[WD_LSB +: WD_W] == O_CNT
                     && (chNum(adrQ) == c
                     || (syncSel[c] && syncSel[chNum(adrQ)]));
      allFree = allFree && ctrl[c][CT_CL +: 3] == CL_NONE;
    end
  end

  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < NCH; c++) cnt[c] <= CNT_ZERO;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (presetNow[c]) cnt[c] <= hwdata[CW-1:0];
        else if (clrNow[c]) cnt[c] <= CNT_ZERO;
        else if (tick[c] && up[c]) cnt[c] <= cnt[c] + CNT_ONE;
        else if (tick[c]) cnt[c] <= cnt[c] - CNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // general registers, hardware transfers win over a bus write
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < NCH; c++) begin
        for (int g = 0; g < NGR; g++) gr[c][g] <= GR_RST;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        for (int g = 0; g < NGR; g++) begin
          if (chWr[c] && adrQ[WD_LSB +: WD_W] == O_GRA + 4'(g)) begin
            gr[c][g] <= hwdata[CW-1:0];
          end
        end
        for (int g = 0; g < GR_PAIR; g++) begin
          if (capEv[c][g]) gr[c][g] <= cnt[c];
          if (BUF_CH[c] && ctrl[c][CT_BUFA + g]) begin
            if (capEv[c][g]) gr[c][g + GR_PAIR] <= gr[c][g];
            if (matchEv[c][g]) gr[c][g] <= gr[c][g + GR_PAIR];
          end
        end
        for (int g = GR_PAIR; g < NGR; g++) begin
          if (capEv[c][g]) gr[c][g] <= cnt[c];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control, flags and interrupt requests
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl[c] <= CTRL_RST;
        io[c] <= '0;
        ier[c] <= '0;
        flg[c] <= '0;
      end
      irqReq <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (chWr[c] && adrQ[WD_LSB +: WD_W] == O_CTRL) begin
          ctrl[c] <= hwdata[CTRL_W-1:0];
        end
        if (chWr[c] && adrQ[WD_LSB +: WD_W] == O_IO) begin
          io[c] <= hwdata[NGR*IO_W-1:0];
        end
        if (chWr[c] && adrQ[WD_LSB +: WD_W] == O_IER) begin
          ier[c] <= hwdata[FLG_W-1:0];
        end
        // write one to clear; a new event in the same cycle survives
        flg[c] <= (flg[c] & ~((chWr[c] && adrQ[WD_LSB +: WD_W] == O_FLG)
                  ? hwdata[FLG_W-1:0] : '0))
                  | {udfEv[c], ovfEv[c], matchEv[c] | capEv[c]};
        irqReq[c] <= |(flg[c] & ier[c]);
      end
    end
  end

  // ------------------------------------------------------------
  // compare outputs; a stopped counter makes no match, so pins hold
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ioOut <= '0;
      ioOe <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        for (int g = 0; g < NGR; g++) begin
          ioOe[c*NGR + g] <= gValid(c, g, ctrl[c])
                             && !io[c][g*IO_W + IO_CAP]
                             && io[c][g*IO_W +: 2] != OM_NONE;
          if (matchEv[c][g]) begin
            case (io[c][g*IO_W +: 2])
              OM_LOW: ioOut[c*NGR + g] <= 1'b0;
              OM_HIGH: ioOut[c*NGR + g] <= 1'b1;
              OM_TOG: ioOut[c*NGR + g] <= ~ioOut[c*NGR + g];
              default: ioOut[c*NGR + g] <= ioOut[c*NGR + g];
            endcase
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  run_count_a: assert property (
    run[2] && ctrl[2][CT_CK +: 3] == CK_DIV1 && !ctrl[2][CT_PHASE]
    && !clrNow[2] && !presetNow[2] |=> cnt[2] == $past(cnt[2]) + CNT_ONE)
    else $error("running channel did not advance");
  stop_hold_a: assert property (
    !run[0] && !presetNow[0] && !clrNow[0]
    |=> $stable(cnt[0]) && $stable(ioOut[NGR-1:0]))
    else $error("stopped channel moved");
  reset_free_a: assert property (
    $fell(sys_rst) |-> allFree)
    else $error("clear source set after reset");
  ovf_wrap_a: assert property (
    ovfEv[0] && !presetNow[0] && !clrNow[0]
    |=> flg[0][FL_OVF] && cnt[0] == CNT_ZERO)
    else $error("overflow not flagged");
  irq_req_a: assert property (
    (flg[3] & ier[3]) != '0 |=> irqReq[3])
    else $error("interrupt not requested");
  period_clr_a: assert property (
    matchEv[1][0] && ctrl[1][CT_CL +: 3] == CL_GRA && !presetNow[1]
    |=> cnt[1] == CNT_ZERO && flg[1][0])
    else $error("periodic clear missed");
  pin_level_a: assert property (
    matchEv[1][0] && io[1][1:0] == OM_HIGH |=> ioOut[NGR])
    else $error("pin not driven high");
  pin_toggle_a: assert property (
    matchEv[1][1] && io[1][IO_W +: 2] == OM_TOG
    |=> ioOut[NGR + 1] != $past(ioOut[NGR + 1]))
    else $error("pin did not toggle");
  capture_a: assert property (
    capEv[2][0] |=> gr[2][0] == $past(cnt[2]))
    else $error("capture value wrong");
  sync_preset_a: assert property (
    presetNow[0] && syncSel[0] && syncSel[1]
    |-> presetNow[1] ##1 cnt[1] == cnt[0])
    else $error("synchronous preset missed");
  buf_compare_a: assert property (
    matchEv[0][0] && ctrl[0][CT_BUFA]
    |=> gr[0][0] == $past(gr[0][GR_PAIR]))
    else $error("buffer not loaded on match");
  buf_capture_a: assert property (
    capEv[3][0] && ctrl[3][CT_BUFA]
    |=> gr[3][GR_PAIR] == $past(gr[3][0]) && gr[3][0] == $past(cnt[3]))
    else $error("capture buffer transfer wrong");
  cascade_a: assert property (
    run[1] && ctrl[1][CT_CK +: 3] == CK_CASC && !ctrl[1][CT_PHASE]
    && ovfEv[2] && !clrNow[1] && !presetNow[1]
    |=> cnt[1] == $past(cnt[1]) + CNT_ONE)
    else $error("upper half did not count");
endmodule // mct_timer
